// ==== hw/scc_arb.sv ====
// serial bitwise contention among arbitration fields
`timescale 1ns/10ps
`include "scc_defs.svh"
module scc_arb (
    // clock and reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // arbitration bundle
    scc_arb_if.arb    ab
);
    scc_pkg::scc_arb_st_t st_r, st_nxt;
    logic [4:0]  alive_r, alive_nxt;
    logic [2:0]  bit_r, bit_nxt;
    logic [2:0]  win_r, win_nxt;
    logic        spur_r, spur_nxt;
    logic [4:0]  hi;
    always_comb begin
        st_nxt = st_r;
        alive_nxt = alive_r;
        bit_nxt = bit_r;
        win_nxt = win_r;
        spur_nxt = spur_r;
        hi = '0;
        for (int i = 0; i < 5; i++)
            hi[i] = alive_r[i] & ab.prio[i*4 + int'(bit_r)];
        case (st_r)
            scc_pkg::SCC_ARB_IDLE: begin
                // contention runs even for one request
                if (ab.start) begin
                    alive_nxt = ab.req;
                    bit_nxt = 3'h3;
                    st_nxt = scc_pkg::SCC_ARB_RUN;
                end
            end
            scc_pkg::SCC_ARB_RUN: begin
                if (|hi)
                    alive_nxt = hi;
                if (bit_r == 3'h0) begin
                    st_nxt = scc_pkg::SCC_ARB_DONE;
                    win_nxt = 3'h0;
                    for (int i = 4; i >= 0; i--)
                        if ((|hi ? hi[i] : alive_r[i]))
                            win_nxt = 3'(i);
                    spur_nxt = (ab.prio[int'(win_nxt)*4 +: 4] == 4'h0);
                end else begin
                    bit_nxt = bit_r - 3'h1;
                end
            end
            default: st_nxt = scc_pkg::SCC_ARB_IDLE;
        endcase
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= scc_pkg::SCC_ARB_IDLE;
            alive_r <= 5'h00;
            bit_r <= 3'h0;
            win_r <= 3'h0;
            spur_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            alive_r <= alive_nxt;
            bit_r <= bit_nxt;
            win_r <= win_nxt;
            spur_r <= spur_nxt;
        end
    end
    assign ab.done = (st_r == scc_pkg::SCC_ARB_DONE);
    assign ab.winner = win_r;
    assign ab.spurious = spur_r;
endmodule

// ==== hw/scc_arb_if.sv ====
// arbitration request and result bundle
`timescale 1ns/10ps
interface scc_arb_if;
    logic [4:0]  req;
    logic [19:0] prio;
    logic        start;
    logic        done;
    logic [2:0]  winner;
    logic        spurious;
    modport ctl (output req, output prio, output start,
                 input done, input winner, input spurious);
    modport arb (input req, input prio, input start,
                 output done, output winner, output spurious);
endinterface

// ==== hw/scc_defs.svh ====
// constants of the system configuration block
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH
`define SCC_OFF_CFG      8'h00
`define SCC_OFF_STAT     8'h04
`define SCC_OFF_ARB0     8'h08
`define SCC_BLK_LO       24'h7ff000
`define SCC_BLK_HI       24'hfff000
`define SCC_BLK_MASK     24'hfff000
`define SCC_BIT_MM       15
`define SCC_BIT_HALT_BUS_MONITOR_BIT    14
`define SCC_BIT_HALT_WATCHDOG_BIT    13
`define SCC_BIT_SUPERVISOR_BIT     12
`define SCC_SHOW_CYCLE_FIELD_HI      9
`define SCC_SHOW_CYCLE_FIELD_LO      8
`define SCC_ARB_HI       3
`define SCC_ARB_LO       0
`define SCC_ARB_OWN_RST  4'hf
`define SCC_ARB_MOD_RST  4'h0
`define SCC_NMOD         4
`define SCC_CONT_BITS    3'h4
`endif

// ==== hw/scc_pkg.sv ====
// types of the system configuration block
package scc_pkg;
    typedef enum logic [1:0] {
        SCC_SHOW_OFF  = 2'b00,
        SCC_SHOW_NOAR = 2'b01,
        SCC_SHOW_ARB  = 2'b10,
        SCC_SHOW_HALT = 2'b11
    } scc_show_t;
    typedef enum logic [1:0] {
        SCC_ARB_IDLE = 2'b00,
        SCC_ARB_RUN  = 2'b01,
        SCC_ARB_DONE = 2'b10
    } scc_arb_st_t;
endpackage

// ==== hw/scc_top.sv ====
// system configuration: mapping, arbitration, show, freeze, clock source
// Contract
// - control registers in one 4-Kbyte block
// - block at 7ff000 or fff000 by map; only fff000 is decoded here, 7ff000 is never selected
// - address 23..20 follow address 19
// - map bit is bus address bit 23
// - map bit resets one, one write
// - cleared map hides modules until reset
// - same priority resolved by bitwise contention
// - contention runs on every acknowledge
// - zero field request gives spurious exception
// - own field arbitrates external against internal
// - own field resets ones, others zero
// - show field 00/01/10 decode
// - show field 11 halts on grant
// - always supervisor, supervisor bit ignored
// - core raises freeze on debug breakpoint
// - halt and spurious monitors keep running
// - freeze bit stops bus monitor
// - freeze bit stops watchdog and timer
// - clock pin high selects synthesizer
// - clock pin low: external clock input
// - rate change keeps contents
// - one reference type per variant
// - held in reset until lock
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "scc_defs.svh"
module scc_top #(
    parameter logic FAST_REF = 1'b1
) (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [15:0] reg_rdata_o,
    // address lines
    input  wire logic [19:0] addr_low_i,
    input  wire logic        addr_ext_drv_i,
    input  wire logic [3:0]  addr_ext_i,
    output logic      [23:0] addr_o,
    input  wire logic [23:0] mod_addr_i,
    output logic             mod_sel_o,
    // interrupt contention
    input  wire logic [3:0]  mod_req_i,
    input  wire logic [15:0] mod_prio_i,
    input  wire logic        ext_req_i,
    input  wire logic        iack_i,
    output logic             iack_done_o,
    output logic [2:0]       iack_winner_o,
    output logic             spurious_o,
    // show cycles and arbitration
    input  wire logic        ext_grant_i,
    output logic             show_en_o,
    output logic             ext_arb_en_o,
    output logic             int_halt_o,
    // freeze
    input  wire logic        debug_halt_i,
    output logic             bus_mon_en_o,
    output logic             watchdog_en_o,
    output logic             pit_en_o,
    output logic             halt_mon_en_o,
    output logic             spur_mon_en_o,
    // clock source
    input  wire logic        clock_source_pin_i,
    input  wire logic        synth_lock_flag_i,
    output logic             synth_en_o,
    output logic             fast_ref_o,
    output logic             core_rst_o
);
    scc_arb_if ab ();
    logic        map_r, map_nxt;
    logic        once_r, once_nxt;
    logic        halt_bus_monitor_bit_r, halt_bus_monitor_bit_nxt;
    logic        halt_watchdog_bit_r, halt_watchdog_bit_nxt;
    logic        supervisor_bit_r, supervisor_bit_nxt;
    logic [1:0]  show_cycle_field_r, show_cycle_field_nxt;
    logic [3:0]  arb_own_r, arb_own_nxt;
    logic [15:0] rd_r, rd_nxt;
    logic        src_r, src_nxt;
    logic        held_r, held_nxt;
    logic        cfg_wr;
    scc_pkg::scc_show_t show;

    function automatic logic [15:0] cfg_word(input logic m, input logic b,
                                             input logic w, input logic s,
                                             input logic [1:0] sh,
                                             input logic [3:0] ar);
        logic [15:0] v;
        v = 16'h0000;
        v[`SCC_BIT_MM] = m;
        v[`SCC_BIT_HALT_BUS_MONITOR_BIT] = b;
        v[`SCC_BIT_HALT_WATCHDOG_BIT] = w;
        v[`SCC_BIT_SUPERVISOR_BIT] = s;
        v[`SCC_SHOW_CYCLE_FIELD_HI:`SCC_SHOW_CYCLE_FIELD_LO] = sh;
        v[`SCC_ARB_HI:`SCC_ARB_LO] = ar;
        return v;
    endfunction

    assign cfg_wr = reg_wr_i && (reg_addr_i == `SCC_OFF_CFG);

    always_comb begin
        map_nxt = map_r;
        once_nxt = once_r;
        halt_bus_monitor_bit_nxt = halt_bus_monitor_bit_r;
        halt_watchdog_bit_nxt = halt_watchdog_bit_r;
        supervisor_bit_nxt = supervisor_bit_r;
        show_cycle_field_nxt = show_cycle_field_r;
        arb_own_nxt = arb_own_r;
        rd_nxt = 16'h0000;
        if (cfg_wr) begin
            // first write marks map bit used
            once_nxt = 1'b1;
            if (!once_r)
                map_nxt = reg_wdata_i[`SCC_BIT_MM];
            halt_bus_monitor_bit_nxt = reg_wdata_i[`SCC_BIT_HALT_BUS_MONITOR_BIT];
            halt_watchdog_bit_nxt = reg_wdata_i[`SCC_BIT_HALT_WATCHDOG_BIT];
            supervisor_bit_nxt = reg_wdata_i[`SCC_BIT_SUPERVISOR_BIT];
            show_cycle_field_nxt = reg_wdata_i[`SCC_SHOW_CYCLE_FIELD_HI:`SCC_SHOW_CYCLE_FIELD_LO];
            arb_own_nxt = reg_wdata_i[`SCC_ARB_HI:`SCC_ARB_LO];
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                `SCC_OFF_CFG:
                    rd_nxt = cfg_word(map_r, halt_bus_monitor_bit_r, halt_watchdog_bit_r, supervisor_bit_r,
                                      show_cycle_field_r, arb_own_r);
                `SCC_OFF_STAT:
                    rd_nxt = {11'h000, once_r, src_r, synth_lock_flag_i,
                              FAST_REF, spurious_o};
                default: rd_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            map_r <= 1'b1;
            once_r <= 1'b0;
            halt_bus_monitor_bit_r <= 1'b0;
            halt_watchdog_bit_r <= 1'b0;
            supervisor_bit_r <= 1'b1;
            show_cycle_field_r <= 2'h0;
            arb_own_r <= `SCC_ARB_OWN_RST;
            rd_r <= 16'h0000;
        end else begin
            map_r <= map_nxt;
            once_r <= once_nxt;
            halt_bus_monitor_bit_r <= halt_bus_monitor_bit_nxt;
            halt_watchdog_bit_r <= halt_watchdog_bit_nxt;
            supervisor_bit_r <= supervisor_bit_nxt;
            show_cycle_field_r <= show_cycle_field_nxt;
            arb_own_r <= arb_own_nxt;
            rd_r <= rd_nxt;
        end
    end
    assign reg_rdata_o = rd_r;

    assign addr_o = {(addr_ext_drv_i ? addr_ext_i : {4{addr_low_i[19]}}),
                     addr_low_i};
    // decode of the 4 Kbyte block
    assign mod_sel_o = ((mod_addr_i & `SCC_BLK_MASK) ==
                        (map_r ? `SCC_BLK_HI : `SCC_BLK_LO)) && map_r;

    assign ab.req = {ext_req_i, mod_req_i};
    assign ab.prio = {arb_own_r, mod_prio_i};
    assign ab.start = iack_i;
    scc_arb u_arb (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .ab      (ab)
    );
    assign iack_done_o = ab.done;
    assign iack_winner_o = ab.winner;
    assign spurious_o = ab.done & ab.spurious;

    assign show = scc_pkg::scc_show_t'(show_cycle_field_r);
    always_comb begin
        show_en_o = 1'b1;
        ext_arb_en_o = 1'b1;
        int_halt_o = 1'b0;
        case (show)
            scc_pkg::SCC_SHOW_OFF:  show_en_o = 1'b0;
            scc_pkg::SCC_SHOW_NOAR: ext_arb_en_o = 1'b0;
            scc_pkg::SCC_SHOW_ARB:  ext_arb_en_o = 1'b1;
            scc_pkg::SCC_SHOW_HALT: int_halt_o = ext_grant_i;
            default:                show_en_o = 1'b0;
        endcase
    end

    assign bus_mon_en_o = !(halt_bus_monitor_bit_r && debug_halt_i);
    assign watchdog_en_o = !(halt_watchdog_bit_r && debug_halt_i);
    assign pit_en_o = !(halt_watchdog_bit_r && debug_halt_i);
    assign halt_mon_en_o = 1'b1;
    assign spur_mon_en_o = 1'b1;

    // sample clock pin while reset held
    always_comb begin
        src_nxt = held_r ? clock_source_pin_i : src_r;
        // wait for lock when synthesizer used
        held_nxt = held_r && !(!clock_source_pin_i || synth_lock_flag_i);
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            src_r <= 1'b1;
            held_r <= 1'b1;
        end else begin
            src_r <= src_nxt;
            held_r <= held_nxt;
        end
    end
    assign synth_en_o = src_r;
    // one reference type fixed per build
    assign fast_ref_o = FAST_REF;
    // registers are static, no clear on rate change
    assign core_rst_o = held_r;

    // map bit unchanged after first write
    property p_once;
        @(posedge clock_i) disable iff (rst_i)
        once_r |=> map_r == $past(map_r);
    endproperty
    a_once: assert property (p_once) else $error("map bit rewritten");
    property p_hide;
        @(posedge clock_i) disable iff (rst_i)
        !map_r |-> !mod_sel_o;
    endproperty
    a_hide: assert property (p_hide) else $error("modules reachable");
    property p_addr;
        @(posedge clock_i) disable iff (rst_i)
        !addr_ext_drv_i |-> addr_o[23:20] == {4{addr_low_i[19]}};
    endproperty
    a_addr: assert property (p_addr) else $error("upper lines wrong");
    property p_arb;
        @(posedge clock_i) disable iff (rst_i)
        iack_i && !ab.done && !ab.start ##0 1'b1 |-> ##[1:6] ab.done;
    endproperty
    property p_run;
        @(posedge clock_i) disable iff (rst_i)
        $rose(ab.done) |-> $past(iack_i, 5);
    endproperty
    a_run: assert property (p_run) else $error("contention length");
    property p_show;
        @(posedge clock_i) disable iff (rst_i)
        show_cycle_field_r == 2'b01 |-> show_en_o && !ext_arb_en_o;
    endproperty
    a_show: assert property (p_show) else $error("show decode");
    property p_grant;
        @(posedge clock_i) disable iff (rst_i)
        show_cycle_field_r == 2'b11 && ext_grant_i |-> int_halt_o;
    endproperty
    a_grant: assert property (p_grant) else $error("no halt on grant");
    property p_halt_bus_monitor_bit;
        @(posedge clock_i) disable iff (rst_i)
        halt_bus_monitor_bit_r && debug_halt_i |-> !bus_mon_en_o && halt_mon_en_o;
    endproperty
    a_halt_bus_monitor_bit: assert property (p_halt_bus_monitor_bit) else $error("bus monitor on");
    property p_halt_watchdog_bit;
        @(posedge clock_i) disable iff (rst_i)
        halt_watchdog_bit_r && debug_halt_i |-> !watchdog_en_o && !pit_en_o;
    endproperty
    a_halt_watchdog_bit: assert property (p_halt_watchdog_bit) else $error("watchdog on");
    property p_lock;
        @(posedge clock_i) disable iff (rst_i)
        src_r && !synth_lock_flag_i && held_r |=> core_rst_o;
    endproperty
    a_lock: assert property (p_lock) else $error("left reset unlocked");
endmodule

// ==== testbench/scc_periph_model.sv ====
// peripheral modules holding their requests and arbitration fields
`timescale 1ns/10ps
module scc_periph_model (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // setup from the bench
    input  wire logic        set_i,
    input  wire logic [3:0]  set_req_i,
    input  wire logic [15:0] set_prio_i,
    // toward the block
    output logic      [3:0]  mod_req_o,
    output logic      [15:0] mod_prio_o
);
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            mod_req_o  <= 4'h0;
            mod_prio_o <= 16'h0000;
        end else if (set_i) begin
            mod_req_o  <= set_req_i;
            mod_prio_o <= set_prio_i;
        end
    end
endmodule

// ==== testbench/system_config_control_tb.sv ====
// self-checking bench of the system configuration block
`timescale 1ns/10ps
module system_config_control_tb;
    logic        clock_i, rst_i, wr, rd, drv, ext_req, iack, grant, dbg;
    logic        pin, lock, set, done, sp, sel, show, arb_en, halt;
    logic        busm, wdog, pit, hmon, smon, syn, fref, crst;
    logic [7:0]  addr;
    logic [15:0] wdata, rdata, prio, set_prio;
    logic [19:0] alow;
    logic [3:0]  aext, req, set_req;
    logic [23:0] addr_o, maddr;
    logic [2:0]  win;
    int          errors, cmp_count, cyc;

    scc_top #(.FAST_REF(1'b1)) dut_u (.clock_i(clock_i), .rst_i(rst_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .addr_low_i(alow),
        .addr_ext_drv_i(drv), .addr_ext_i(aext), .addr_o(addr_o),
        .mod_addr_i(maddr), .mod_sel_o(sel), .mod_req_i(req),
        .mod_prio_i(prio), .ext_req_i(ext_req), .iack_i(iack),
        .iack_done_o(done), .iack_winner_o(win), .spurious_o(sp),
        .ext_grant_i(grant), .show_en_o(show), .ext_arb_en_o(arb_en),
        .int_halt_o(halt), .debug_halt_i(dbg), .bus_mon_en_o(busm),
        .watchdog_en_o(wdog), .pit_en_o(pit), .halt_mon_en_o(hmon),
        .spur_mon_en_o(smon), .clock_source_pin_i(pin),
        .synth_lock_flag_i(lock), .synth_en_o(syn), .fast_ref_o(fref),
        .core_rst_o(crst));

    scc_periph_model pm_u (.clock_i(clock_i), .rst_i(rst_i), .set_i(set),
        .set_req_i(set_req), .set_prio_i(set_prio), .mod_req_o(req),
        .mod_prio_o(prio));

    always #50 clock_i = ~clock_i;

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            tally_and_finish;
        end
    end

    task automatic chk(input string nm, input logic [23:0] e,
                       input logic [23:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock_i);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, input logic [15:0] e);
        @(posedge clock_i);
        rd <= 1'b1; addr <= a;
        @(posedge clock_i);
        rd <= 1'b0;
        #1 chk("reg_rdata", e, rdata);
    endtask

    task automatic do_reset;
        @(posedge clock_i);
        rst_i <= 1'b1;
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        #1;
    endtask

    task automatic sel_at(input logic [23:0] a, input logic e);
        @(posedge clock_i);
        maddr <= a;
        #1 chk("mod_sel", e, sel);
    endtask

    task automatic ack(input logic [3:0] r, input logic [15:0] p,
                       input logic x, input logic [2:0] ew, input logic es);
        int n;
        @(posedge clock_i);
        set <= 1'b1; set_req <= r; set_prio <= p; ext_req <= x;
        @(posedge clock_i);
        set <= 1'b0; iack <= 1'b1;
        @(posedge clock_i);
        iack <= 1'b0;
        n = 0;
        do begin
            @(posedge clock_i);
            #1 n++;
        end while (done !== 1'b1 && n < 20);
        chk("done_delay", 24'd4, 24'(n));
        chk("spurious", es, sp);
        if (!es) chk("winner", ew, win);
    endtask

    initial begin
        clock_i = 0; rst_i = 1; wr = 0; rd = 0; addr = 0; wdata = 0;
        alow = 0; drv = 0; aext = 0; maddr = 0; ext_req = 0; iack = 0;
        grant = 0; dbg = 0; pin = 1; lock = 0; set = 0; set_req = 0;
        set_prio = 0; errors = 0; cmp_count = 0; cyc = 0;
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        #1 chk("core_rst", 1, crst);
        chk("synth_en", 1, syn);
        rreg(8'h00, 16'h900f);
        rreg(8'h04, 16'h000a);
        @(posedge clock_i);
        lock <= 1'b1;
        repeat (3) @(posedge clock_i);
        #1 chk("core_rst", 0, crst);
        rreg(8'h04, 16'h000e);
        @(posedge clock_i);
        alow <= 20'h80123;
        #1 chk("addr", 24'hf80123, addr_o);
        @(posedge clock_i);
        drv <= 1'b1; aext <= 4'h5;
        #1 chk("addr", 24'h580123, addr_o);
        @(posedge clock_i);
        drv <= 1'b0; alow <= 20'h01234;
        #1 chk("addr", 24'h001234, addr_o);
        sel_at(24'hfff010, 1);
        sel_at(24'h7ff010, 0);
        sel_at(24'hffe010, 0);
        wreg(8'h00, 16'h0000);
        rreg(8'h04, 16'h001e);
        sel_at(24'hfff010, 0);
        sel_at(24'h7ff010, 0);
        wreg(8'h00, 16'h8000);
        rreg(8'h00, 16'h0000);
        sel_at(24'hfff010, 0);
        pin <= 1'b0;
        do_reset;
        chk("synth_en", 0, syn);
        chk("core_rst", 0, crst);
        rreg(8'h04, 16'h0006);
        rreg(8'h00, 16'h900f);
        sel_at(24'hfff010, 1);
        wreg(8'h00, 16'h800f);
        wreg(8'h00, 16'h000f);
        rreg(8'h00, 16'h800f);
        for (int s = 0; s < 4; s++) begin
            wreg(8'h00, 16'h800f | 16'(s << 8));
            grant <= 1'b1;
            @(posedge clock_i);
            #1 chk("show_en", s != 0, show);
            chk("ext_arb_en", s != 1, arb_en);
            chk("int_halt", s == 3, halt);
            grant <= 1'b0;
            @(posedge clock_i);
            #1 chk("int_halt", 0, halt);
        end
        for (int k = 0; k < 8; k++) begin
            wreg(8'h00, 16'h800f | 16'((k & 3) << 13));
            dbg <= k[2];
            @(posedge clock_i);
            #1 chk("bus_mon_en", !(k[2] & k[1]), busm);
            chk("watchdog_en", !(k[2] & k[0]), wdog);
            chk("pit_en", !(k[2] & k[0]), pit);
            chk("halt_mon_en", 1, hmon);
            chk("spur_mon_en", 1, smon);
        end
        dbg <= 1'b0;
        wreg(8'h00, 16'h800f);
        ack(4'b0110, 16'h0950, 0, 3'd2, 0);
        ack(4'b0001, 16'h0003, 0, 3'd0, 0);
        ack(4'b0100, 16'h0000, 0, 3'd0, 1);
        ack(4'b0000, 16'h0000, 1, 3'd4, 0);
        ack(4'b1010, 16'h7070, 0, 3'd1, 0);
        ack(4'b0001, 16'h0003, 1, 3'd4, 0);
        wreg(8'h00, 16'h8002);
        ack(4'b0001, 16'h0003, 1, 3'd0, 0);
        rreg(8'h40, 16'h0000);
        tally_and_finish;
    end
endmodule
